// file: hdl/mide_core.sv
// decode and execute unit for file, skip, bit-skip and literal ops
// assumes file_rd_data answers file_rd_addr in the same cycle
//
// Function
// RQ1: add with carry: W plus f plus C
// RQ2: subtract with borrow: f minus W minus borrow
// RQ3: rotate right through carry, only C changes
// RQ4: rotate left through carry, only C changes
// RQ5: OR W with file register, Z only
// RQ6: XOR W with file register, Z only
// RQ7: decrement, skip when zero, no flags
// RQ8: increment, skip when zero, no flags
// RQ9: bit test, skip when selected bit clear
// RQ10: bit test, skip when selected bit set
// RQ11: OR literal into W, Z only
// RQ12: literal minus W into W, all three flags
// RQ13: XOR literal into W, Z only
// RQ14: load seven-bit literal into PC high latch
// RQ15: taken skip costs two instruction cycles
// RQ16: extra cycle is a no-operation
// RQ17: indirect access with pointer MSb adds cycle
// RQ18: destination bit picks W or file register
// RQ19: top two bits choose instruction class
`timescale 1ns/1ps

module mide_core
(
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           reset,
    // instruction issue
    input  wire logic                           instr_valid,
    input  wire logic [mide_pkg::WORD_W-1:0]    instr_word,
    output logic                                instr_ready,
    // file register read and write
    output logic [mide_pkg::FADDR_W-1:0]        file_rd_addr,
    input  wire logic [mide_pkg::DATA_W-1:0]    file_rd_data,
    output mide_pkg::mide_file_wr_s             file_wr,
    // indirect pointer MSbs
    input  wire logic                           pointer0_msb,
    input  wire logic                           pointer1_msb,
    // execution results
    output logic [mide_pkg::DATA_W-1:0]         w_out,
    output logic [mide_pkg::DATA_W-1:0]         status_out,
    output logic [mide_pkg::PCH_W-1:0]          pc_high_latch_out,
    output logic                                skip_taken,
    output logic                                unsupported,
    // register port
    input  wire logic [mide_pkg::RADDR_W-1:0]   reg_addr,
    input  wire logic [mide_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic [mide_pkg::DATA_W-1:0]         reg_rdata
);
    import mide_pkg::*;

    // ***************************************************************
    // decode
    // ***************************************************************

    // class from the top bits, then the opcode nibble
    function automatic mide_op_e decode_op(input logic [13:0] iw);
        mide_op_e   op;
        logic [3:0] nib;
        op  = OP_NOP;
        nib = iw[NIB_HI:NIB_LO];
        unique case (iw[CLS_HI:CLS_LO])                     // [RQ19]
            CLS_BYTE:
            begin
                if (nib == NIB_OR_FILE)       op = OP_OR_FILE;
                else if (nib == NIB_XOR_FILE) op = OP_XOR_FILE;
                else if (nib == NIB_RR_FILE)  op = OP_ROTATE_RIGHT_FILE;
                else if (nib == NIB_RL_FILE)  op = OP_ROTATE_LEFT_FILE;
                else if (nib == NIB_DEC_SKIP) op = OP_DEC_SKIP_ZERO;
                else if (nib == NIB_INC_SKIP) op = OP_INC_SKIP_ZERO;
            end
            CLS_BIT:
            begin
                if (iw[BKIND_HI:BKIND_LO] == BKIND_SKIP_CLR)
                    op = OP_BIT_TEST_SKIP_CLEAR;            // [RQ9]
                else if (iw[BKIND_HI:BKIND_LO] == BKIND_SKIP_SET)
                    op = OP_BIT_TEST_SKIP_SET;              // [RQ10]
            end
            CLS_LIT:
            begin
                if (nib == NIB_ADDC_FILE)      op = OP_ADD_CARRY_FILE;
                else if (nib == NIB_SUBB_FILE) op = OP_SUB_BORROW_FILE;
                else if (nib == NIB_OR_LIT)    op = OP_OR_LITERAL;
                else if (nib == NIB_XOR_LIT)   op = OP_XOR_LITERAL;
                else if (nib == NIB_SUB_LIT)   op = OP_SUB_FROM_LITERAL;
                else if (nib == NIB_LOAD_PCH && iw[PCH_TAG_B])
                    op = OP_LOAD_PC_HIGH_LATCH;             // [RQ14]
            end
            default: op = OP_NOP;
        endcase
        return op;
    endfunction

    // true for ops that read the addressed file register
    function automatic logic uses_file(input mide_op_e op);
        return !(op inside {OP_NOP, OP_OR_LITERAL, OP_XOR_LITERAL,
                            OP_SUB_FROM_LITERAL, OP_LOAD_PC_HIGH_LATCH});
    endfunction

    // ***************************************************************
    // state
    // ***************************************************************
    logic [7:0]   w_reg;
    logic [7:0]   w_next;
    logic [7:0]   status_reg;
    logic [7:0]   status_next;
    logic [6:0]   pch_reg;
    logic [6:0]   pch_next;
    logic [1:0]   extra_reg;
    logic         skip_reg;
    logic         unsup_reg;
    logic [7:0]   rdata_reg;
    mide_file_wr_s fwr_reg;

    mide_op_e     op;
    mide_result_s res;
    logic         take;
    logic         indirect_slow;
    logic [7:0]   lit;
    logic [2:0]   bsel;
    logic         dest_f;
    logic         c_in;
    logic [8:0]   sum;
    logic [4:0]   nsum;

    assign op           = decode_op(instr_word);
    assign instr_ready  = (extra_reg == 2'h0);              // [RQ15]
    assign take         = instr_valid && instr_ready;
    assign file_rd_addr = instr_word[FADDR_W-1:0];          // [RQ18]
    assign lit          = instr_word[DATA_W-1:0];
    assign bsel         = instr_word[BSEL_HI:BSEL_LO];
    assign dest_f       = instr_word[DEST_B];
    assign c_in         = status_reg[ST_C];

    // pointer MSb on an indirect address costs one cycle
    // literal ops carry no file address, so they never stall
    assign indirect_slow = uses_file(op)
        && ((file_rd_addr == IND0_ADDR && pointer0_msb)
            || (file_rd_addr == IND1_ADDR && pointer1_msb)); // [RQ17]

    // ***************************************************************
    // execute
    // ***************************************************************

    // adders shared by the arithmetic ops
    always_comb
    begin
        sum  = 9'h000;
        nsum = 5'h00;
        unique case (op)
            OP_ADD_CARRY_FILE:                              // [RQ1]
            begin
                sum  = {1'b0, w_reg} + {1'b0, file_rd_data} + {8'h00, c_in};
                nsum = {1'b0, w_reg[3:0]} + {1'b0, file_rd_data[3:0]}
                     + {4'h0, c_in};
            end
            OP_SUB_BORROW_FILE:                             // [RQ2]
            begin
                sum  = {1'b0, file_rd_data} + {1'b0, ~w_reg}
                     + {8'h00, c_in};
                nsum = {1'b0, file_rd_data[3:0]} + {1'b0, ~w_reg[3:0]}
                     + {4'h0, c_in};
            end
            OP_SUB_FROM_LITERAL:                            // [RQ12]
            begin
                sum  = {1'b0, lit} + {1'b0, ~w_reg} + 9'h001;
                nsum = {1'b0, lit[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01;
            end
            default:
            begin
                sum  = 9'h000;
                nsum = 5'h00;
            end
        endcase
    end

    // result, flag updates, destination and skip
    always_comb
    begin
        res        = '0;
        res.to_f   = dest_f && uses_file(op)
                   && !(op inside {OP_BIT_TEST_SKIP_CLEAR,
                                   OP_BIT_TEST_SKIP_SET}); // [RQ18]
        res.to_w   = !dest_f && res.to_f == 1'b0 && uses_file(op)
                   && !(op inside {OP_BIT_TEST_SKIP_CLEAR,
                                   OP_BIT_TEST_SKIP_SET});
        unique case (op)
            OP_ADD_CARRY_FILE, OP_SUB_BORROW_FILE:          // [RQ1] [RQ2]
            begin
                res.value = sum[7:0];
                {res.wr_c, res.wr_hc, res.wr_z} = 3'h7;
            end
            OP_SUB_FROM_LITERAL:                            // [RQ12]
            begin
                res.value = sum[7:0];
                res.to_w  = 1'b1;
                {res.wr_c, res.wr_hc, res.wr_z} = 3'h7;
            end
            OP_ROTATE_RIGHT_FILE:                           // [RQ3]
            begin
                res.value = {c_in, file_rd_data[7:1]};
                res.c     = file_rd_data[0];
                res.wr_c  = 1'b1;
            end
            OP_ROTATE_LEFT_FILE:                            // [RQ4]
            begin
                res.value = {file_rd_data[6:0], c_in};
                res.c     = file_rd_data[7];
                res.wr_c  = 1'b1;
            end
            OP_OR_FILE:                                     // [RQ5]
            begin
                res.value = w_reg | file_rd_data;
                res.wr_z  = 1'b1;
            end
            OP_XOR_FILE:                                    // [RQ6]
            begin
                res.value = w_reg ^ file_rd_data;
                res.wr_z  = 1'b1;
            end
            OP_DEC_SKIP_ZERO:                               // [RQ7]
            begin
                res.value = file_rd_data - 8'h01;
                res.skip  = (res.value == 8'h00);
            end
            OP_INC_SKIP_ZERO:                               // [RQ8]
            begin
                res.value = file_rd_data + 8'h01;
                res.skip  = (res.value == 8'h00);
            end
            OP_BIT_TEST_SKIP_CLEAR: res.skip = !file_rd_data[bsel]; // [RQ9]
            OP_BIT_TEST_SKIP_SET:   res.skip = file_rd_data[bsel];  // [RQ10]
            OP_OR_LITERAL:                                  // [RQ11]
            begin
                res.value = w_reg | lit;
                res.to_w  = 1'b1;
                res.wr_z  = 1'b1;
            end
            OP_XOR_LITERAL:                                 // [RQ13]
            begin
                res.value = w_reg ^ lit;
                res.to_w  = 1'b1;
                res.wr_z  = 1'b1;
            end
            default: res.value = 8'h00;
        endcase
        // subtract carry is the inverted borrow
        if (op inside {OP_ADD_CARRY_FILE, OP_SUB_BORROW_FILE,
                       OP_SUB_FROM_LITERAL})
        begin
            res.c  = sum[8];
            res.hc = nsum[4];
        end
        res.z = (res.value == 8'h00);
    end

    // ***************************************************************
    // architectural registers
    // ***************************************************************

    // next values, execution wins over a same-cycle port write
    always_comb
    begin
        w_next      = w_reg;
        status_next = status_reg;
        pch_next    = pch_reg;
        if (reg_wr && reg_addr == OFF_W)
            w_next = reg_wdata;
        if (reg_wr && reg_addr == OFF_STATUS)
            status_next = reg_wdata & STATUS_MASK;
        if (reg_wr && reg_addr == OFF_PCH)
            pch_next = reg_wdata[PCH_W-1:0];
        if (take)                                           // [RQ16]
        begin
            if (res.to_w)
                w_next = res.value;                         // [RQ18]
            if (res.wr_c || res.wr_hc || res.wr_z)
                status_next = status_reg;
            if (res.wr_c)
                status_next[ST_C] = res.c;
            if (res.wr_hc)
                status_next[ST_HC] = res.hc;
            if (res.wr_z)
                status_next[ST_Z] = res.z;
            if (op == OP_LOAD_PC_HIGH_LATCH)
                pch_next = lit[PCH_W-1:0];                  // [RQ14]
        end
    end

    // working register, status and high latch
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            w_reg      <= W_RST;
            status_reg <= STATUS_RST;
            pch_reg    <= PCH_RST;
        end
        else
        begin
            w_reg      <= w_next;
            status_reg <= status_next;
            pch_reg    <= pch_next;
        end
    end

    // file write back, pulsed one cycle after the issue cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            fwr_reg <= '0;
        else
        begin
            fwr_reg.en   <= take && res.to_f;               // [RQ18]
            fwr_reg.addr <= file_rd_addr;
            fwr_reg.data <= res.value;
        end
    end

    // extra no-op cycles: taken skip plus slow indirect
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            extra_reg <= 2'h0;
        else if (take)
            extra_reg <= {1'b0, res.skip}
                       + {1'b0, indirect_slow};             // [RQ15] [RQ17]
        else if (extra_reg != 2'h0)
            extra_reg <= extra_reg - 2'h1;                  // [RQ16]
    end

    // skip and unsupported-opcode pulses
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            skip_reg  <= 1'b0;
            unsup_reg <= 1'b0;
        end
        else
        begin
            skip_reg  <= take && res.skip;
            unsup_reg <= take && op == OP_NOP;
        end
    end

    // register port read data, one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdata_reg <= 8'h00;
        else if (reg_rd)
            unique case (reg_addr)
                OFF_W:      rdata_reg <= w_reg;
                OFF_STATUS: rdata_reg <= status_reg;
                OFF_PCH:    rdata_reg <= {1'b0, pch_reg};
                default:    rdata_reg <= 8'h00;
            endcase
        else
            rdata_reg <= 8'h00;
    end

    assign w_out             = w_reg;
    assign status_out        = status_reg;
    assign pc_high_latch_out = pch_reg;
    assign file_wr           = fwr_reg;
    assign skip_taken        = skip_reg;
    assign unsupported       = unsup_reg;
    assign reg_rdata         = rdata_reg;

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_one_nop;
        !instr_ready ##1 instr_ready;
    endsequence

    sequence s_two_nop;
        !instr_ready [*2] ##1 instr_ready;
    endsequence

    a_skip_two_cycle: assert property (                     // [RQ15]
        take && res.skip && !indirect_slow |=> s_one_nop)
        else $error("taken skip did not cost one extra cycle");

    a_indirect_extra: assert property (                     // [RQ17]
        take && indirect_slow && res.skip |=> s_two_nop)
        else $error("indirect skip did not cost two extra cycles");

    a_nop_cycle_quiet: assert property (                    // [RQ16]
        !instr_ready && !reg_wr |=> !file_wr.en && $stable(w_reg)
            && $stable(status_reg))
        else $error("state changed during a no-op cycle");

    a_add_carry_sum: assert property (                      // [RQ1]
        take && op == OP_ADD_CARRY_FILE && !dest_f
        |=> {status_reg[ST_C], w_reg} == {1'b0, $past(w_reg)}
            + {1'b0, $past(file_rd_data)} + {8'h00, $past(c_in)})
        else $error("add with carry gave a wrong sum");

    a_sub_literal: assert property (                        // [RQ12]
        take && op == OP_SUB_FROM_LITERAL
        |=> w_reg == 8'($past(lit) - $past(w_reg))
            && status_reg[ST_C] == ($past(lit) >= $past(w_reg)))
        else $error("literal subtract gave a wrong result");

    a_rotate_carry: assert property (                       // [RQ3]
        take && op == OP_ROTATE_RIGHT_FILE
        |=> status_reg[ST_C] == $past(file_rd_data[0])
            && status_reg[ST_Z] == $past(status_reg[ST_Z]))
        else $error("rotate right touched a flag other than carry");

    a_or_file_zero: assert property (                       // [RQ5]
        take && op == OP_OR_FILE && !dest_f
        |=> w_reg == ($past(w_reg) | $past(file_rd_data))
            && status_reg[ST_Z] == (w_reg == 8'h00))
        else $error("OR to W gave a wrong value or zero flag");

    a_dest_file: assert property (                          // [RQ18]
        take && res.to_f |=> file_wr.en
            && file_wr.addr == $past(instr_word[6:0])
            && ($stable(w_reg) || $past(reg_wr)))
        else $error("file destination not written back");

    a_pch_load: assert property (                           // [RQ14]
        take && op == OP_LOAD_PC_HIGH_LATCH
        |=> pc_high_latch_out == $past(instr_word[6:0]))
        else $error("high latch not loaded from the literal");

    a_bit_skip_set: assert property (                       // [RQ10]
        take && op == OP_BIT_TEST_SKIP_SET && file_rd_data[bsel]
        |=> skip_taken ##1 !skip_taken)
        else $error("bit set test did not skip");

    a_dec_skip_flags: assert property (                     // [RQ7]
        take && op == OP_DEC_SKIP_ZERO && file_rd_data == 8'h01
        |=> skip_taken && ($stable(status_reg) || $past(reg_wr)))
        else $error("decrement skip missed or changed flags");

endmodule // mide_core

// file: shared/mide_pkg.sv
// constants, operation codes and carriers for the decode/execute unit
// assumes a 14-bit instruction word and an 8-bit banked file register
package mide_pkg;

    // ***************************************************************
    // widths and instruction fields
    // ***************************************************************
    localparam int unsigned WORD_W  = 14;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned FADDR_W = 7;
    localparam int unsigned PCH_W   = 7;
    localparam int unsigned RADDR_W = 2;

    localparam int unsigned CLS_HI  = 13;  // class field, top two bits
    localparam int unsigned CLS_LO  = 12;
    localparam int unsigned NIB_HI  = 11;  // opcode nibble
    localparam int unsigned NIB_LO  = 8;
    localparam int unsigned DEST_B  = 7;   // destination select bit
    localparam int unsigned BSEL_HI = 9;   // bit select of bit ops
    localparam int unsigned BSEL_LO = 7;
    localparam int unsigned BKIND_HI = 11; // bit op kind
    localparam int unsigned BKIND_LO = 10;
    localparam int unsigned PCH_TAG_B = 7; // fixed one ahead of literal

    // ***************************************************************
    // class and opcode encodings
    // ***************************************************************
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT  = 2'h1;
    localparam logic [1:0] CLS_LIT  = 2'h3;

    localparam logic [3:0] NIB_OR_FILE   = 4'h4;
    localparam logic [3:0] NIB_XOR_FILE  = 4'h6;
    localparam logic [3:0] NIB_DEC_SKIP  = 4'hb;
    localparam logic [3:0] NIB_RR_FILE   = 4'hc;
    localparam logic [3:0] NIB_RL_FILE   = 4'hd;
    localparam logic [3:0] NIB_INC_SKIP  = 4'hf;
    localparam logic [3:0] NIB_ADDC_FILE = 4'hd;
    localparam logic [3:0] NIB_SUBB_FILE = 4'hb;
    localparam logic [3:0] NIB_OR_LIT    = 4'h8;
    localparam logic [3:0] NIB_XOR_LIT   = 4'ha;
    localparam logic [3:0] NIB_SUB_LIT   = 4'hc;
    localparam logic [3:0] NIB_LOAD_PCH  = 4'h1;
    localparam logic [1:0] BKIND_SKIP_CLR = 2'h2;
    localparam logic [1:0] BKIND_SKIP_SET = 2'h3;

    // indirect access registers and their pointers
    localparam logic [6:0] IND0_ADDR = 7'h00;
    localparam logic [6:0] IND1_ADDR = 7'h01;

    // ***************************************************************
    // register port map, status layout, reset values
    // ***************************************************************
    localparam logic [1:0] OFF_W      = 2'h0;
    localparam logic [1:0] OFF_STATUS = 2'h1;
    localparam logic [1:0] OFF_PCH    = 2'h2;
    localparam int unsigned ST_C  = 0;
    localparam int unsigned ST_HC = 1;
    localparam int unsigned ST_Z  = 2;
    localparam logic [7:0] W_RST      = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [6:0] PCH_RST    = 7'h00;
    localparam logic [7:0] STATUS_MASK = 8'h07;

    typedef enum {
        OP_NOP, OP_ADD_CARRY_FILE, OP_SUB_BORROW_FILE,
        OP_ROTATE_RIGHT_FILE, OP_ROTATE_LEFT_FILE, OP_OR_FILE,
        OP_XOR_FILE, OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO,
        OP_BIT_TEST_SKIP_CLEAR, OP_BIT_TEST_SKIP_SET, OP_OR_LITERAL,
        OP_SUB_FROM_LITERAL, OP_XOR_LITERAL, OP_LOAD_PC_HIGH_LATCH
    } mide_op_e;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
        logic       en;
    } mide_file_wr_s;

    typedef struct packed {
        logic [7:0] value;
        logic       c;
        logic       hc;
        logic       z;
        logic       wr_c;
        logic       wr_hc;
        logic       wr_z;
        logic       to_w;
        logic       to_f;
        logic       skip;
    } mide_result_s;

endpackage

// file: testbench/mide_file_model.sv
// file register model standing behind the decode/execute unit
// assumes combinational reads and writes on the file_wr pulse
`timescale 1ns/1ps

module mide_file_model
(
    // clock
    input  wire logic                    clk_sys,
    // file access
    input  wire logic [6:0]              rd_addr,
    output logic [7:0]                   rd_data,
    input  wire mide_pkg::mide_file_wr_s wr
);
    import mide_pkg::*;

    logic [7:0] mem [128];

    // same-cycle answer to the read address
    assign rd_data = mem[rd_addr];

    // write back on the one-cycle pulse
    always @(posedge clk_sys)
    begin
        if (wr.en)
        begin
            mem[wr.addr] <= wr.data;
        end
    end
endmodule // mide_file_model

// file: testbench/midrange_instr_decode_exec_tb_top.sv
// self-checking bench for the decode/execute unit
// assumes the file register model and the design package
`timescale 1ns/1ps

module midrange_instr_decode_exec_tb_top;
    import mide_pkg::*;

    typedef struct packed {
        logic [13:0] wd;
        logic [7:0]  fv, w, st;
        logic        sk;
        logic [1:0]  n;
        logic [7:0]  fe;
    } mide_tv_s;

    // ***************************************************************
    // signals and instances
    // ***************************************************************
    logic          clk_sys     = 1'b0;
    logic          reset       = 1'b1;
    logic          instr_valid = 1'b0;
    logic [13:0]   instr_word  = 14'h0000;
    logic          pointer0_msb = 1'b1;
    logic          pointer1_msb = 1'b1;
    logic [1:0]    reg_addr    = 2'h0;
    logic [7:0]    reg_wdata   = 8'h00;
    logic          reg_wr      = 1'b0;
    logic          reg_rd      = 1'b0;
    logic          instr_ready, skip_taken, unsupported;
    logic [6:0]    file_rd_addr, pch;
    logic [7:0]    file_rd_data, w_out, status_out, reg_rdata;
    mide_file_wr_s file_wr;
    int            miscompares = 0;
    int            cmp_count   = 0;
    int            cyc         = 0;

    // start: W=0f, status=07; file address 0 and 1 are slow indirect
    mide_tv_s tv [21] = '{
        '{14'h0405, 8'hf0, 8'hff, 8'h03, 1'b0, 2'h0, 8'hf0},
        '{14'h3aff, 8'h00, 8'h00, 8'h07, 1'b0, 2'h0, 8'h00},
        '{14'h3812, 8'h00, 8'h12, 8'h03, 1'b0, 2'h0, 8'h00},
        '{14'h0685, 8'hf0, 8'h12, 8'h03, 1'b0, 2'h0, 8'he2},
        '{14'h3c10, 8'h00, 8'hfe, 8'h00, 1'b0, 2'h0, 8'h00},
        '{14'h3d05, 8'he2, 8'he0, 8'h03, 1'b0, 2'h0, 8'he2},
        '{14'h3b05, 8'he2, 8'h02, 8'h03, 1'b0, 2'h0, 8'he2},
        '{14'h0c05, 8'he2, 8'hf1, 8'h02, 1'b0, 2'h0, 8'he2},
        '{14'h0d05, 8'he2, 8'hc4, 8'h03, 1'b0, 2'h0, 8'he2},
        '{14'h0b86, 8'h01, 8'hc4, 8'h03, 1'b1, 2'h1, 8'h00},
        '{14'h0b86, 8'h02, 8'hc4, 8'h03, 1'b0, 2'h0, 8'h01},
        '{14'h0f86, 8'hff, 8'hc4, 8'h03, 1'b1, 2'h1, 8'h00},
        '{14'h0f86, 8'h00, 8'hc4, 8'h03, 1'b0, 2'h0, 8'h01},
        '{14'h1807, 8'h80, 8'hc4, 8'h03, 1'b1, 2'h1, 8'h80},
        '{14'h1b87, 8'h80, 8'hc4, 8'h03, 1'b0, 2'h0, 8'h80},
        '{14'h1f87, 8'h80, 8'hc4, 8'h03, 1'b1, 2'h1, 8'h80},
        '{14'h1c07, 8'h80, 8'hc4, 8'h03, 1'b0, 2'h0, 8'h80},
        '{14'h31d5, 8'h00, 8'hc4, 8'h03, 1'b0, 2'h0, 8'h00},
        '{14'h0400, 8'h00, 8'hc4, 8'h03, 1'b0, 2'h1, 8'h00},
        '{14'h0b80, 8'h01, 8'hc4, 8'h03, 1'b1, 2'h2, 8'h00},
        '{14'h0601, 8'h04, 8'hc0, 8'h03, 1'b0, 2'h1, 8'h04}
    };

    mide_core i_mide_core (.clk_sys(clk_sys), .reset(reset),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .file_rd_addr(file_rd_addr),
        .file_rd_data(file_rd_data), .file_wr(file_wr),
        .pointer0_msb(pointer0_msb), .pointer1_msb(pointer1_msb),
        .w_out(w_out), .status_out(status_out), .pc_high_latch_out(pch),
        .skip_taken(skip_taken), .unsupported(unsupported),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    mide_file_model i_mide_file_model (.clk_sys(clk_sys),
        .rd_addr(file_rd_addr), .rd_data(file_rd_data), .wr(file_wr));

    // ***************************************************************
    // clock, timeout and access tasks
    // ***************************************************************
    always #5 clk_sys = ~clk_sys;

    // cut a hang short
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    // issue one word, count refused cycles, then check results
    task automatic ex(input mide_tv_s t, input logic us_exp = 1'b0);
        logic sk;
        logic us;
        int   n;
        @(posedge clk_sys);
        i_mide_file_model.mem[t.wd[6:0]] = t.fv;
        instr_word  <= t.wd;
        instr_valid <= 1'b1;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1 sk = skip_taken;
        us = unsupported;
        n = 0;
        while (instr_ready !== 1'b1 && n < 4)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        @(posedge clk_sys);
        #1 chk(w_out, t.w);
        chk(status_out, t.st);
        chk({7'h00, sk}, {7'h00, t.sk});
        chk({7'h00, us}, {7'h00, us_exp});
        chk(n[7:0], {6'h00, t.n});
        chk(i_mide_file_model.mem[t.wd[6:0]], t.fe);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rd(OFF_W, W_RST);
        rd(OFF_STATUS, STATUS_RST);
        rd(OFF_PCH, 8'h00);
        wr(OFF_STATUS, 8'hff);
        rd(OFF_STATUS, 8'h07);
        wr(OFF_W, 8'h0f);
        rd(2'h3, 8'h00);
        $display("test register port done");
        foreach (tv[i])
        begin
            ex(tv[i]);
            $display("test %0d done", i);
        end
        // unhandled byte op: plain one-cycle nop with a pulse
        ex(mide_tv_s'{14'h0705, 8'h5a, 8'hc0, 8'h03, 1'b0, 2'h0,
                      8'h5a}, 1'b1);
        $display("test unsupported opcode done");
        // pointer MSb clear: indirect address costs nothing
        @(posedge clk_sys);
        pointer0_msb <= 1'b0;
        ex(mide_tv_s'{14'h0400, 8'h00, 8'hc0, 8'h03, 1'b0, 2'h0,
                      8'h00});
        $display("test pointer clear done");
        rd(OFF_PCH, 8'h55);
        chk({1'b0, pch}, 8'h55);
        conclude();
    end
endmodule // midrange_instr_decode_exec_tb_top
